// [pkg/smc_pkg.sv]
package smc_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 125_000_000;
    localparam int unsigned MS_PER_S         = 1000;
    localparam int unsigned TICK_CYCLES      = CLK_HZ / MS_PER_S;
    localparam int unsigned PWRUP_WAIT_S     = 2;
    localparam int unsigned PWRUP_WAIT_MS    = PWRUP_WAIT_S * MS_PER_S;
    localparam int unsigned SIMUL_S          = 3;
    localparam int unsigned SIMUL_MS         = SIMUL_S * MS_PER_S;
    localparam int unsigned DEB_MAX_MS       = 1500;
    localparam int unsigned LIMIT_STEP_MS    = 100;
    localparam int unsigned LIMIT_MAX_STEPS  = 18000;
    localparam logic [14:0] LIMIT_DEF_STEPS  = 15'h012c;
    localparam int unsigned TMR_W            = 22;
    localparam int unsigned DEB_W            = 11;
    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        SMC_PWRUP = 4'h1,
        SMC_IDLE  = 4'h2,
        SMC_START = 4'h4,
        SMC_MUTED = 4'h8
    } smc_state_t;
endpackage

// [design/smc_mute_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_mute_ctrl
    import smc_pkg::*;
#(
    // cycles per ms tick; a short value lets a bench reach the ms timers
    parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // sensor, guard and operator pins
    input  wire logic        pair_a_sensor_one,
    input  wire logic        pair_a_sensor_two,
    input  wire logic        pair_b_sensor_one,
    input  wire logic        pair_b_sensor_two,
    input  wire logic        mute_permit_input,
    input  wire logic        guard_run,
    input  wire logic        powerup_reset,
    // configuration
    input  wire logic        cfg_pair_b_used,
    input  wire logic        cfg_permit_used,
    input  wire logic        cfg_pwrup_mute,
    input  wire logic        cfg_pwrup_auto,
    input  wire logic [10:0] cfg_deb_open_ms,
    input  wire logic [10:0] cfg_deb_close_ms,
    input  wire logic [14:0] cfg_limit_steps,
    input  wire logic        cfg_limit_inf,
    // status
    output logic             mute_active,
    output logic             guard_out,
    output logic             simul_fault,
    output logic             limit_expired
);
    import smc_pkg::*;

    // the divider is 17 bits, and the tick check needs two quiet cycles
    if (TICK_DIV < 3 || TICK_DIV > 131072) begin : g_bad_tick
        $error("tick divider out of range");
    end

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    // pins cross from the field, so two flops before any use
    logic [6:0] pin_raw;
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    assign pin_raw = {powerup_reset, guard_run, mute_permit_input, pair_b_sensor_two,
                      pair_b_sensor_one, pair_a_sensor_two, pair_a_sensor_one};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        smc_state_t         st;
        logic [16:0]        div;
        logic               tick;
        logic [TMR_W-1:0]   pwr_ms;
        logic [TMR_W-1:0]   sim_ms;
        logic [TMR_W-1:0]   lim_ms;
        logic [DEB_W-1:0]   deb_ms;
        logic               timing;
        logic               sim_bad;
        logic               permit_d;
        logic               permit_cut;
        logic               sim_reset_used;
        logic               rst_d;
        logic               expired;
        logic               guard;
        logic [1:0]         settle;
        logic               armed;
    } smc_reg_t;

    smc_reg_t r;
    smc_reg_t nxt;

    logic pa;
    logic pb;
    logic pa_any;
    logic pb_any;
    logic any_sens;
    logic pair_on;
    logic permit_ok;
    logic run;
    logic pwr_cond;
    logic rst_rise;
    logic lim_hit;
    logic [DEB_W-1:0] close_lim;

    always_comb begin
        pa        = sync2_r[0] & sync2_r[1];
        pb        = cfg_pair_b_used & sync2_r[2] & sync2_r[3];
        pa_any    = sync2_r[0] | sync2_r[1];
        pb_any    = cfg_pair_b_used & (sync2_r[2] | sync2_r[3]);
        any_sens  = pa_any | pb_any;
        pair_on   = pa | pb;
        permit_ok = ~cfg_permit_used | sync2_r[4];
        run       = sync2_r[5];
        rst_rise  = sync2_r[6] & ~r.rst_d;
        pwr_cond  = permit_ok & run & (pa ^ pb);
        lim_hit   = ~cfg_limit_inf &&
                    (r.lim_ms >= TMR_W'(cfg_limit_steps) * TMR_W'(LIMIT_STEP_MS));
        close_lim = (cfg_deb_close_ms > DEB_W'(DEB_MAX_MS)) ? DEB_W'(DEB_MAX_MS)
                                                            : cfg_deb_close_ms;
    end

    always_comb begin
        nxt          = r;
        nxt.rst_d    = sync2_r[6];
        nxt.permit_d = sync2_r[4];
        nxt.tick = 1'b0;
        if (r.div == 17'(TICK_DIV - 1)) begin
            nxt.div  = 17'h00000;
            nxt.tick = 1'b1;
        end else begin
            nxt.div = r.div + 17'h00001;
        end
        // a request is a fresh close; synced pins read open just after reset
        if (r.settle != 2'h3) begin
            nxt.settle = r.settle + 2'h1;
        end
        if (pair_on) begin
            nxt.armed = 1'b0;
        end else if (r.settle == 2'h3) begin
            nxt.armed = 1'b1;
        end
        if (!any_sens) begin
            nxt.timing         = 1'b0;
            nxt.sim_bad        = 1'b0;
            nxt.sim_ms         = '0;
            nxt.sim_reset_used = 1'b0;
            nxt.permit_cut     = 1'b0;
        end else if (!pair_on) begin
            if (!r.timing) begin
                nxt.timing = 1'b1;
                nxt.sim_ms = '0;
            end else if (r.tick && !r.sim_bad) begin
                nxt.sim_ms = r.sim_ms + TMR_W'(1);
                if (r.sim_ms >= TMR_W'(SIMUL_MS - 1)) begin
                    nxt.sim_bad = 1'b1;
                end
            end
            if (cfg_permit_used && !sync2_r[4] && r.permit_d) begin
                nxt.permit_cut = 1'b1;
            end
            if (r.permit_cut && sync2_r[4] && !r.sim_reset_used) begin
                nxt.sim_ms         = '0;
                nxt.sim_bad        = 1'b0;
                nxt.sim_reset_used = 1'b1;
                nxt.permit_cut     = 1'b0;
            end
        end
        case (r.st)
            SMC_PWRUP: begin
                if (r.tick) begin
                    nxt.pwr_ms = r.pwr_ms + TMR_W'(1);
                end
                if (!cfg_pwrup_mute) begin
                    nxt.st = SMC_IDLE;
                end else if (cfg_pwrup_auto) begin
                    if (pwr_cond) begin
                        nxt.st = SMC_MUTED;
                        nxt.lim_ms = '0;
                    end else if (r.pwr_ms >= TMR_W'(PWRUP_WAIT_MS)) begin
                        nxt.st = SMC_IDLE;
                    end
                end else if (rst_rise) begin
                    nxt.st     = pwr_cond ? SMC_MUTED : SMC_IDLE;
                    nxt.lim_ms = '0;
                end
            end
            SMC_IDLE: begin
                nxt.deb_ms = '0;
                if (pair_on && r.armed && run && !r.sim_bad && permit_ok) begin
                    nxt.st = SMC_START;
                end
            end
            SMC_START: begin
                if (!pair_on || !run || !permit_ok) begin
                    nxt.st = SMC_IDLE;
                end else if (r.deb_ms >= cfg_deb_open_ms) begin
                    nxt.st     = SMC_MUTED;
                    nxt.lim_ms = '0;
                    nxt.deb_ms = '0;
                end else if (r.tick) begin
                    nxt.deb_ms = r.deb_ms + DEB_W'(1);
                end
            end
            SMC_MUTED: begin
                if (r.tick) begin
                    nxt.lim_ms = r.lim_ms + TMR_W'(1);
                end
                if (lim_hit) begin
                    nxt.st      = SMC_IDLE;
                    nxt.expired = 1'b1;
                end else if (pair_on) begin
                    nxt.deb_ms = '0;
                end else if (r.deb_ms >= close_lim) begin
                    nxt.st = SMC_IDLE;
                end else if (r.tick) begin
                    nxt.deb_ms = r.deb_ms + DEB_W'(1);
                end
            end
            default: nxt.st = SMC_IDLE;
        endcase
        if (r.st != SMC_MUTED && nxt.st == SMC_MUTED) begin
            nxt.expired = 1'b0;
        end
        nxt.guard = run | (nxt.st == SMC_MUTED);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r    <= '0;
            r.st <= SMC_PWRUP;
        end else begin
            r <= nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign mute_active   = r.st[3];
    assign guard_out     = r.guard;
    assign simul_fault   = r.sim_bad;
    assign limit_expired = r.expired;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_enter;
        !mute_active ##1 mute_active;
    endsequence

    a_mute_guard_on: assert property (mute_active |-> guard_out)
        else $error("guard output dropped while muted");
    a_enter_needs_pair: assert property (s_enter |-> $past(pair_on, 2) || $past(r.st, 1) == SMC_PWRUP)
        else $error("mute entered without a closed pair");
    a_no_both_pwrup: assert property ((r.st == SMC_PWRUP && pa && pb) |=> r.st != SMC_MUTED)
        else $error("power-up mute with both pairs closed");
    a_sim_blocks: assert property ((r.st == SMC_IDLE && r.sim_bad) |=> r.st != SMC_START)
        else $error("start despite simultaneity fault");
    a_limit_ends: assert property ((mute_active && lim_hit) |=> !mute_active && limit_expired)
        else $error("mute outlived its limit");
    a_ext_holds: assert property ((mute_active && !pair_on && !lim_hit && r.deb_ms < close_lim) |=> mute_active)
        else $error("mute ended before extension");
    a_ext_capped: assert property ((mute_active && !pair_on && !lim_hit && r.deb_ms >= close_lim) |=> !mute_active)
        else $error("mute outlived its extension");
    a_start_fresh: assert property ((r.st == SMC_IDLE && !r.armed) |=> r.st != SMC_START)
        else $error("start without a fresh pair close");
    a_permit_start: assert property ((r.st == SMC_START && cfg_permit_used && !sync2_r[4]) |=> !mute_active)
        else $error("mute started without permit");
    a_open_delay: assert property ((r.st == SMC_START && r.deb_ms < cfg_deb_open_ms) |=> !mute_active)
        else $error("mute started before open delay");
    a_tick_period: assert property (r.tick |=> !r.tick [*2])
        else $error("tick too frequent");
endmodule
`default_nettype wire

// [test/smc_field_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smc_field_model (
    // clock
    input  wire logic clk,
    // mute sensor pairs
    output var logic  pair_a_sensor_one,
    output var logic  pair_a_sensor_two,
    output var logic  pair_b_sensor_one,
    output var logic  pair_b_sensor_two,
    // guard device and operator inputs
    output var logic  mute_permit_input,
    output var logic  guard_run,
    output var logic  powerup_reset
);
    // ---------------------------------------------------------------
    // field devices
    // ---------------------------------------------------------------
    initial begin
        pair_a_sensor_one = 1'b0;
        pair_a_sensor_two = 1'b0;
        pair_b_sensor_one = 1'b0;
        pair_b_sensor_two = 1'b0;
        mute_permit_input = 1'b0;
        guard_run         = 1'b0;
        powerup_reset     = 1'b0;
    end
    // both channels together
    // pairs move as one so the simultaneity window is always met
    task automatic set_pair_a(input logic v);
        @(posedge clk);
        pair_a_sensor_one <= v;
        pair_a_sensor_two <= v;
    endtask
    // one sensor alone, to open a simultaneity window
    task automatic set_a_sensor(input logic which, input logic v);
        @(posedge clk);
        if (which) begin
            pair_a_sensor_two <= v;
        end else begin
            pair_a_sensor_one <= v;
        end
    endtask
    task automatic set_pair_b(input logic v);
        @(posedge clk);
        pair_b_sensor_one <= v;
        pair_b_sensor_two <= v;
    endtask
    task automatic set_guard(input logic run, input logic permit);
        @(posedge clk);
        guard_run         <= run;
        mute_permit_input <= permit;
    endtask
    // held several cycles so the synchroniser sees a clean rise
    task automatic pulse_reset;
        @(posedge clk);
        powerup_reset <= 1'b1;
        repeat (4) @(posedge clk);
        powerup_reset <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    import smc_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        pa1, pa2, pb1, pb2, permit, run, pwr_rst;
    logic        cfg_pwrup_mute = 1'b0;
    logic        cfg_pwrup_auto = 1'b0;
    logic        cfg_pair_b_used = 1'b1;
    logic        cfg_permit_used = 1'b1;
    logic        cfg_limit_inf = 1'b1;
    logic [14:0] cfg_limit_steps = LIMIT_DEF_STEPS;
    logic [10:0] dopen = 11'h000;
    logic [10:0] dclose = 11'h000;
    logic        mute_active, guard_out, simul_fault, limit_expired;
    int          n_errors = 0;
    int          tests_run = 0;
    always #4 clk = ~clk;
    smc_field_model smc_field_model_i (.clk(clk), .pair_a_sensor_one(pa1),
        .pair_a_sensor_two(pa2), .pair_b_sensor_one(pb1), .pair_b_sensor_two(pb2),
        .mute_permit_input(permit), .guard_run(run), .powerup_reset(pwr_rst));
    // 4 cycles per ms keeps the 3 s window within the run
    smc_mute_ctrl #(.TICK_DIV(4)) smc_mute_ctrl_i (.clk(clk), .arst_n(arst_n),
        .pair_a_sensor_one(pa1), .pair_a_sensor_two(pa2), .pair_b_sensor_one(pb1),
        .pair_b_sensor_two(pb2), .mute_permit_input(permit), .guard_run(run),
        .powerup_reset(pwr_rst), .cfg_pair_b_used(cfg_pair_b_used),
        .cfg_permit_used(cfg_permit_used), .cfg_pwrup_mute(cfg_pwrup_mute),
        .cfg_pwrup_auto(cfg_pwrup_auto), .cfg_deb_open_ms(dopen),
        .cfg_deb_close_ms(dclose), .cfg_limit_steps(cfg_limit_steps),
        .cfg_limit_inf(cfg_limit_inf), .mute_active(mute_active), .guard_out(guard_out),
        .simul_fault(simul_fault), .limit_expired(limit_expired));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait; the caller compares afterwards
    task automatic wait_mute(input logic exp, input int n = 60);
        int i;
        for (i = 0; i < n && mute_active !== exp; i++) cyc(1);
    endtask
    task automatic do_reset(input logic pm, input logic au, input logic [10:0] op,
                            input logic [10:0] cl);
        @(posedge clk);
        arst_n         <= 1'b0;
        cfg_pwrup_mute <= pm;
        cfg_pwrup_auto <= au;
        dopen          <= op;
        dclose         <= cl;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        cyc(5);
    endtask
    task automatic mute_pair_a;
        smc_field_model_i.set_guard(1'b1, 1'b1);
        smc_field_model_i.set_pair_a(1'b1);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_manual;
        mute_pair_a();
        do_reset(1'b1, 1'b0, 11'h000, 11'h000);
        chk(mute_active, 1'b0);
        smc_field_model_i.pulse_reset();
        wait_mute(1'b1);
        chk(mute_active, 1'b1);
        smc_field_model_i.set_guard(1'b0, 1'b0);
        cyc(8);
        chk(guard_out, 1'b1);
        chk(mute_active, 1'b1);
        smc_field_model_i.set_pair_a(1'b0);
        wait_mute(1'b0);
        chk(mute_active, 1'b0);
        chk(guard_out, 1'b0);
    endtask
    task automatic t_both_pairs;
        mute_pair_a();
        smc_field_model_i.set_pair_b(1'b1);
        do_reset(1'b1, 1'b0, 11'h000, 11'h000);
        smc_field_model_i.pulse_reset();
        cyc(60);
        chk(mute_active, 1'b0);
        smc_field_model_i.set_pair_a(1'b0);
        smc_field_model_i.set_pair_b(1'b0);
    endtask
    task automatic t_auto;
        smc_field_model_i.set_guard(1'b1, 1'b1);
        smc_field_model_i.set_pair_b(1'b1);
        do_reset(1'b1, 1'b1, 11'h000, 11'h000);
        wait_mute(1'b1);
        chk(mute_active, 1'b1);
        smc_field_model_i.set_pair_b(1'b0);
        wait_mute(1'b0);
        chk(mute_active, 1'b0);
    endtask
    task automatic t_normal;
        smc_field_model_i.set_guard(1'b0, 1'b1);
        do_reset(1'b0, 1'b0, 11'h000, 11'h000);
        smc_field_model_i.pulse_reset();
        cyc(8);
        smc_field_model_i.set_pair_a(1'b1);
        cyc(60);
        chk(mute_active, 1'b0);
        smc_field_model_i.set_pair_a(1'b0);
        smc_field_model_i.set_guard(1'b1, 1'b0);
        cyc(8);
        smc_field_model_i.set_pair_a(1'b1);
        cyc(60);
        chk(mute_active, 1'b0);
        smc_field_model_i.set_pair_a(1'b0);
        cyc(8);
        mute_pair_a();
        wait_mute(1'b1);
        chk(mute_active, 1'b1);
        chk(simul_fault, 1'b0);
        chk(limit_expired, 1'b0);
        smc_field_model_i.set_pair_a(1'b0);
        cyc(8);
        @(posedge clk);
        cfg_permit_used <= 1'b0;
        smc_field_model_i.set_guard(1'b1, 1'b0);
        smc_field_model_i.set_pair_a(1'b1);
        wait_mute(1'b1);
        chk(mute_active, 1'b1);
        smc_field_model_i.set_pair_a(1'b0);
        wait_mute(1'b0);
        @(posedge clk);
        cfg_permit_used <= 1'b1;
        cyc(4);
    endtask
    // 10 steps of 100 ms are 4000 cycles at 4 cycles per ms
    task automatic t_limit;
        @(posedge clk);
        cfg_limit_inf   <= 1'b0;
        cfg_limit_steps <= 15'h000a;
        mute_pair_a();
        wait_mute(1'b1);
        cyc(3900);
        chk(mute_active, 1'b1);
        wait_mute(1'b0, 300);
        chk(mute_active, 1'b0);
        chk(limit_expired, 1'b1);
        chk(guard_out, 1'b1);
        smc_field_model_i.set_pair_a(1'b0);
        @(posedge clk);
        cfg_limit_inf <= 1'b1;
        cyc(8);
    endtask
    task automatic t_simul;
        @(posedge clk);
        cfg_pair_b_used <= 1'b0;
        smc_field_model_i.set_pair_b(1'b1);
        cyc(30);
        chk(mute_active, 1'b0);
        smc_field_model_i.set_pair_b(1'b0);
        @(posedge clk);
        cfg_pair_b_used <= 1'b1;
        cyc(8);
        smc_field_model_i.set_a_sensor(1'b0, 1'b1);
        cyc(12100);
        chk(simul_fault, 1'b1);
        smc_field_model_i.set_a_sensor(1'b1, 1'b1);
        cyc(20);
        chk(mute_active, 1'b0);
        smc_field_model_i.set_a_sensor(1'b1, 1'b0);
        smc_field_model_i.set_guard(1'b1, 1'b0);
        cyc(4);
        smc_field_model_i.set_guard(1'b1, 1'b1);
        cyc(8);
        chk(simul_fault, 1'b0);
        smc_field_model_i.set_a_sensor(1'b1, 1'b1);
        wait_mute(1'b1);
        chk(mute_active, 1'b1);
        chk(limit_expired, 1'b0);
        smc_field_model_i.set_pair_a(1'b0);
        wait_mute(1'b0);
        cyc(4);
    endtask
    // 20 ms is 80 cycles; the 2047 ms setting must be cut to 1500 ms
    task automatic t_debounce;
        smc_field_model_i.set_guard(1'b1, 1'b1);
        do_reset(1'b0, 1'b0, 11'h014, 11'h000);
        smc_field_model_i.set_pair_a(1'b1);
        cyc(40);
        chk(mute_active, 1'b0);
        wait_mute(1'b1, 100);
        chk(mute_active, 1'b1);
        smc_field_model_i.set_pair_a(1'b0);
        do_reset(1'b0, 1'b0, 11'h000, 11'h014);
        smc_field_model_i.set_pair_a(1'b1);
        wait_mute(1'b1);
        smc_field_model_i.set_pair_a(1'b0);
        cyc(40);
        chk(mute_active, 1'b1);
        wait_mute(1'b0, 100);
        chk(mute_active, 1'b0);
        do_reset(1'b0, 1'b0, 11'h000, 11'h7ff);
        smc_field_model_i.set_pair_a(1'b1);
        wait_mute(1'b1);
        smc_field_model_i.set_pair_a(1'b0);
        cyc(5900);
        chk(mute_active, 1'b1);
        wait_mute(1'b0, 400);
        chk(mute_active, 1'b0);
    endtask
    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic conclude;
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400us;
        n_errors++;
        conclude();
    end
    initial begin
        t_manual();
        t_both_pairs();
        t_auto();
        t_normal();
        t_limit();
        t_simul();
        t_debounce();
        conclude();
    end
endmodule
`default_nettype wire
